// *** hw/ispc_pkg.sv ***
// Notes on behaviour
// - Programmer shifts instructions, addresses, data in on TDI by TCK.
// - Device returns data on TDO; programmer captures and compares it.
// - Full run: enter, identity check, erase, program, verify, exit.
// - Verify-only run: enter, identity check, verify, exit; no erase.
// - Enter stage switches pins cleanly; programmer waits its full 1 ms.
// - Exit stage returns pins cleanly; programmer waits its full 1 ms.
// - Identity code is read and checked before any program or verify.
// - Bulk erase: shift erase instruction, then one 100 ms erase pulse.
// - Per address: shift address and data, then wait programming pulse.
// - Per address: shift address, wait read pulse, shift data out.
// - Programmer may be adaptive or constant; this one uses constant.
package ispc_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int ISPC_CLK_MHZ = 200;
  // TCK half period in clk cycles: 10 MHz test clock
  localparam int ISPC_TCK_HALF = 10;
  localparam int ISPC_DIV_W = 5;
  localparam int ISPC_ENTER_US = 1000;
  localparam int ISPC_EXIT_US = 1000;
  localparam int ISPC_ERASE_US = 100000;
  localparam int ISPC_PROG_US = 100;
  localparam int ISPC_READ_US = 1;
  localparam int ISPC_ENTER_CYC = ISPC_ENTER_US * ISPC_CLK_MHZ;
  localparam int ISPC_EXIT_CYC = ISPC_EXIT_US * ISPC_CLK_MHZ;
  localparam int ISPC_ERASE_CYC = ISPC_ERASE_US * ISPC_CLK_MHZ;
  localparam int ISPC_PROG_CYC = ISPC_PROG_US * ISPC_CLK_MHZ;
  localparam int ISPC_READ_CYC = ISPC_READ_US * ISPC_CLK_MHZ;
  // ------------------------------------------------------------------
  // Scan widths and TAP walks
  // ------------------------------------------------------------------
  localparam int ISPC_IR_LEN = 10;
  localparam int ISPC_ID_W = 32;
  localparam int ISPC_SW = 32;
  localparam int ISPC_ADDR_W = 8;
  localparam int ISPC_DATA_W = 16;
  localparam int ISPC_NUM_ADDR = 16;
  // Header TMS patterns, first bit in bit 0; IR and DR entered from run-test idle, reset from any TAP state
  localparam logic [2:0] ISPC_RST_HLEN = 3'h6;
  localparam logic [7:0] ISPC_RST_HPAT = 8'h1F;
  localparam logic [2:0] ISPC_IR_HLEN = 3'h4;
  localparam logic [7:0] ISPC_IR_HPAT = 8'h03;
  localparam logic [2:0] ISPC_DR_HLEN = 3'h3;
  localparam logic [7:0] ISPC_DR_HPAT = 8'h01;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef logic [ISPC_IR_LEN-1:0] ispc_ir_t;
  typedef enum logic [1:0] {SK_RST, SK_IR, SK_DR} ispc_kind_t;
  typedef enum {
    M_IDLE, M_RST, M_ENT_IR, M_ENT_W, M_ID_IR, M_ID_DR, M_ER_IR, M_ER_W,
    M_PG_IR, M_PG_GET, M_PG_DR, M_PG_W, M_VF_IR, M_VF_GET, M_VF_AD,
    M_VF_W, M_VF_DR, M_EX_IR, M_EX_W
  } ispc_state_t;
  typedef struct packed {
    ispc_kind_t kind;
    logic [5:0] len;
    logic [ISPC_SW-1:0] data;
  } ispc_req_t;
  typedef struct packed {
    logic start;
    logic verify_only;
    logic abort;
  } ispc_cmd_t;
  typedef struct packed {
    logic [ISPC_ADDR_W-1:0] addr;
    logic [ISPC_DATA_W-1:0] data;
  } ispc_word_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } ispc_jtag_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic id_ok;
    logic fail;
    logic verify_err;
  } ispc_stat_t;
endpackage : ispc_pkg

// *** hw/ispc_programmer.sv ***
`timescale 1ns/1ps
module ispc_programmer #(
  parameter int ENTER_CYC = ispc_pkg::ISPC_ENTER_CYC,
  parameter int EXIT_CYC = ispc_pkg::ISPC_EXIT_CYC,
  parameter int ERASE_CYC = ispc_pkg::ISPC_ERASE_CYC,
  parameter int PROG_CYC = ispc_pkg::ISPC_PROG_CYC,
  parameter int READ_CYC = ispc_pkg::ISPC_READ_CYC,
  parameter int NUM_ADDR = ispc_pkg::ISPC_NUM_ADDR,
  // Arbitrary value; set to the target part
  parameter logic [31:0] EXPECT_ID = 32'h1357_9BDF,
  // Arbitrary instruction codes
  parameter ispc_pkg::ispc_ir_t IR_ENTER = 10'h011,
  parameter ispc_pkg::ispc_ir_t IR_IDCODE = 10'h012,
  parameter ispc_pkg::ispc_ir_t IR_ERASE = 10'h013,
  parameter ispc_pkg::ispc_ir_t IR_PROG = 10'h014,
  parameter ispc_pkg::ispc_ir_t IR_VERIFY = 10'h015,
  parameter ispc_pkg::ispc_ir_t IR_EXIT = 10'h016
) (
  input wire logic clk,
  input wire logic nrst,
  input ispc_pkg::ispc_cmd_t cmd,
  input wire logic word_valid,
  input ispc_pkg::ispc_word_t word,
  output logic word_ready,
  output ispc_pkg::ispc_jtag_t jtag,
  input wire logic tdo,
  output ispc_pkg::ispc_stat_t stat
);
  import ispc_pkg::*;

  localparam int SCAN_LIMIT = 1000;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------------
  // TDO synchroniser and TCK divider
  // ------------------------------------------------------------------
  logic tdo_m_reg;
  logic tdo_s_reg;
  logic [ISPC_DIV_W-1:0] div_reg;
  logic tck_reg;
  logic wrap;
  logic fall_ev;
  logic rise_ev;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tdo_m_reg <= 1'b0;
      tdo_s_reg <= 1'b0;
    end else begin
      tdo_m_reg <= tdo;
      tdo_s_reg <= tdo_m_reg;
    end
  end

  assign wrap = (div_reg == ISPC_DIV_W'(ISPC_TCK_HALF - 1));
  assign fall_ev = wrap && tck_reg;
  assign rise_ev = wrap && !tck_reg;

  // Free-running TCK; TMS high from reset holds the TAP in test-logic reset, low after each scan parks it in run-test idle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_reg <= '0;
      tck_reg <= 1'b0;
    end else if (wrap) begin
      div_reg <= '0;
      tck_reg <= !tck_reg;
    end else begin
      div_reg <= div_reg + ISPC_DIV_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Two-entry word buffer
  // ------------------------------------------------------------------
  ispc_state_t st_reg;
  ispc_word_t buf_mem [2];
  logic wp_reg;
  logic rp_reg;
  logic [1:0] cnt_reg;
  logic rdy_reg;
  logic [1:0] cnt_next;
  logic buf_valid;
  logic push;
  logic pop;

  assign buf_valid = (cnt_reg != 2'h0);
  assign push = word_valid && rdy_reg;
  assign pop = buf_valid && (st_reg == M_PG_GET || st_reg == M_VF_GET);
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
      rdy_reg <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[wp_reg] <= word;
        wp_reg <= !wp_reg;
      end
      if (pop) begin
        rp_reg <= !rp_reg;
      end
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != 2'h2);
    end
  end

  // ------------------------------------------------------------------
  // Scan engine: TMS/TDI change on TCK fall, TDO taken on TCK rise
  // ------------------------------------------------------------------
  logic req_reg;
  ispc_req_t rq_reg;
  logic sc_run_reg;
  logic sc_pres_reg;
  logic sc_done_reg;
  ispc_kind_t sc_kind_reg;
  logic [5:0] sc_len_reg;
  logic [5:0] sc_step_reg;
  logic [ISPC_SW-1:0] sc_sreg_reg;
  logic tms_reg;
  logic tdi_reg;
  logic [2:0] hlen;
  logic [7:0] hpat;
  logic [5:0] sh;
  logic in_hdr;
  logic in_sh;
  logic tms_v;
  logic last;
  logic [ISPC_SW-1:0] sc_res;

  always_comb begin
    case (sc_kind_reg)
      SK_RST: begin
        hlen = ISPC_RST_HLEN;
        hpat = ISPC_RST_HPAT;
      end
      SK_IR: begin
        hlen = ISPC_IR_HLEN;
        hpat = ISPC_IR_HPAT;
      end
      default: begin
        hlen = ISPC_DR_HLEN;
        hpat = ISPC_DR_HPAT;
      end
    endcase
    sh = sc_step_reg - {3'h0, hlen};
    in_hdr = (sc_step_reg < {3'h0, hlen});
    in_sh = !in_hdr && (sh < sc_len_reg);
    if (in_hdr) begin
      tms_v = hpat[sc_step_reg[2:0]];
    end else if (in_sh) begin
      tms_v = (sh == sc_len_reg - 6'h01);
    end else begin
      tms_v = (sh == sc_len_reg);
    end
    if (sc_len_reg == 6'h00) begin
      last = (sc_step_reg == {3'h0, hlen} - 6'h01);
    end else begin
      last = (sh == sc_len_reg + 6'h01);
    end
  end

  // Captured bits pile up at the top; shift them down to the LSB
  assign sc_res = sc_sreg_reg >> (7'(ISPC_SW) - {1'b0, sc_len_reg});

  always_ff @(posedge clk) begin
    sc_done_reg <= 1'b0;
    if (!nrst) begin
      sc_run_reg <= 1'b0;
      sc_pres_reg <= 1'b0;
      sc_kind_reg <= SK_RST;
      sc_len_reg <= 6'h00;
      sc_step_reg <= 6'h00;
      sc_sreg_reg <= '0;
      tms_reg <= 1'b1;
      tdi_reg <= 1'b0;
    end else if (req_reg) begin
      sc_run_reg <= 1'b1;
      sc_pres_reg <= 1'b0;
      sc_kind_reg <= rq_reg.kind;
      sc_len_reg <= rq_reg.len;
      sc_step_reg <= 6'h00;
      sc_sreg_reg <= rq_reg.data;
    end else if (sc_run_reg && fall_ev) begin
      tms_reg <= tms_v;
      tdi_reg <= in_sh && sc_sreg_reg[0];
      sc_pres_reg <= 1'b1;
    end else if (sc_run_reg && rise_ev && sc_pres_reg) begin
      if (in_sh) begin
        sc_sreg_reg <= {tdo_s_reg, sc_sreg_reg[ISPC_SW-1:1]};
      end
      sc_pres_reg <= 1'b0;
      if (last) begin
        sc_run_reg <= 1'b0;
        sc_done_reg <= 1'b1;
      end else begin
        sc_step_reg <= sc_step_reg + 6'h01;
      end
    end
  end

  tdi_stable_a: assert property ($changed(tdi_reg) |-> !tck_reg)
    else $error("TDI moved while TCK high");
  tms_stable_a: assert property ($changed(tms_reg) |-> !tck_reg)
    else $error("TMS moved while TCK high");

  sequence scan_go_s;
    req_reg ##1 sc_run_reg;
  endsequence
  property scan_end_p;
    scan_go_s |-> ##[1:SCAN_LIMIT] sc_done_reg;
  endproperty
  scan_end_a: assert property (scan_end_p)
    else $error("Scan did not finish in time");

  // ------------------------------------------------------------------
  // Stage sequencer, constant timing throughout
  // ------------------------------------------------------------------
  logic [31:0] tmr_reg;
  logic [15:0] idx_reg;
  logic [ISPC_DATA_W-1:0] exp_reg;
  logic vonly_reg;
  logic abort_reg;
  logic busy_reg;
  logic done_reg;
  logic id_ok_reg;
  logic fail_reg;
  logic verr_reg;
  logic tmr_zero;
  logic last_idx;
  ispc_word_t head;

  assign tmr_zero = (tmr_reg == 32'h0);
  assign last_idx = (idx_reg == 16'(NUM_ADDR - 1));
  assign head = buf_mem[rp_reg];

  function automatic ispc_req_t ir_req(input ispc_ir_t c);
    ir_req = '{SK_IR, 6'(ISPC_IR_LEN), ISPC_SW'(c)};
  endfunction : ir_req

  function automatic ispc_req_t dr_req(input int n, input logic [31:0] d);
    dr_req = '{SK_DR, 6'(n), d};
  endfunction : dr_req

  always_ff @(posedge clk) begin
    req_reg <= 1'b0;
    if (!nrst) begin
      st_reg <= M_IDLE;
      rq_reg <= '{SK_RST, 6'h00, 32'h0};
      tmr_reg <= 32'h0;
      idx_reg <= 16'h0;
      exp_reg <= '0;
      vonly_reg <= 1'b0;
      abort_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      id_ok_reg <= 1'b0;
      fail_reg <= 1'b0;
      verr_reg <= 1'b0;
    end else if (cmd.abort && busy_reg && !abort_reg) begin
      // TAP reset drops the device out of programming mode
      abort_reg <= 1'b1;
      fail_reg <= 1'b1;
      st_reg <= M_RST;
      req_reg <= 1'b1;
      rq_reg <= '{SK_RST, 6'h00, 32'h0};
    end else begin
      if (!tmr_zero) begin
        tmr_reg <= tmr_reg - 32'h1;
      end
      case (st_reg)
        M_IDLE: if (cmd.start) begin
          vonly_reg <= cmd.verify_only;
          abort_reg <= 1'b0;
          done_reg <= 1'b0;
          id_ok_reg <= 1'b0;
          fail_reg <= 1'b0;
          verr_reg <= 1'b0;
          busy_reg <= 1'b1;
          st_reg <= M_RST;
          req_reg <= 1'b1;
          rq_reg <= '{SK_RST, 6'h00, 32'h0};
        end
        M_RST: if (sc_done_reg) begin
          if (abort_reg) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            st_reg <= M_IDLE;
          end else begin
            st_reg <= M_ENT_IR;
            req_reg <= 1'b1;
            rq_reg <= ir_req(IR_ENTER);
          end
        end
        M_ENT_IR: if (sc_done_reg) begin
          tmr_reg <= 32'(ENTER_CYC - 1);
          st_reg <= M_ENT_W;
        end
        M_ENT_W: if (tmr_zero) begin
          st_reg <= M_ID_IR;
          req_reg <= 1'b1;
          rq_reg <= ir_req(IR_IDCODE);
        end
        M_ID_IR: if (sc_done_reg) begin
          st_reg <= M_ID_DR;
          req_reg <= 1'b1;
          rq_reg <= dr_req(ISPC_ID_W, 32'h0);
        end
        M_ID_DR: if (sc_done_reg) begin
          id_ok_reg <= (sc_res == EXPECT_ID);
          req_reg <= 1'b1;
          if (sc_res != EXPECT_ID) begin
            fail_reg <= 1'b1;
            st_reg <= M_EX_IR;
            rq_reg <= ir_req(IR_EXIT);
          end else if (vonly_reg) begin
            st_reg <= M_VF_IR;
            rq_reg <= ir_req(IR_VERIFY);
          end else begin
            st_reg <= M_ER_IR;
            rq_reg <= ir_req(IR_ERASE);
          end
        end
        M_ER_IR: if (sc_done_reg) begin
          tmr_reg <= 32'(ERASE_CYC - 1);
          st_reg <= M_ER_W;
        end
        M_ER_W: if (tmr_zero) begin
          st_reg <= M_PG_IR;
          req_reg <= 1'b1;
          rq_reg <= ir_req(IR_PROG);
        end
        M_PG_IR: if (sc_done_reg) begin
          idx_reg <= 16'h0;
          st_reg <= M_PG_GET;
        end
        // Stalls here until the user supplies the next word
        M_PG_GET: if (pop) begin
          st_reg <= M_PG_DR;
          req_reg <= 1'b1;
          rq_reg <= dr_req(ISPC_ADDR_W + ISPC_DATA_W,
                           32'({head.data, head.addr}));
        end
        M_PG_DR: if (sc_done_reg) begin
          tmr_reg <= 32'(PROG_CYC - 1);
          st_reg <= M_PG_W;
        end
        M_PG_W: if (tmr_zero) begin
          if (last_idx) begin
            st_reg <= M_VF_IR;
            req_reg <= 1'b1;
            rq_reg <= ir_req(IR_VERIFY);
          end else begin
            idx_reg <= idx_reg + 16'h1;
            st_reg <= M_PG_GET;
          end
        end
        M_VF_IR: if (sc_done_reg) begin
          idx_reg <= 16'h0;
          st_reg <= M_VF_GET;
        end
        M_VF_GET: if (pop) begin
          exp_reg <= head.data;
          st_reg <= M_VF_AD;
          req_reg <= 1'b1;
          rq_reg <= dr_req(ISPC_ADDR_W, 32'(head.addr));
        end
        M_VF_AD: if (sc_done_reg) begin
          tmr_reg <= 32'(READ_CYC - 1);
          st_reg <= M_VF_W;
        end
        M_VF_W: if (tmr_zero) begin
          st_reg <= M_VF_DR;
          req_reg <= 1'b1;
          rq_reg <= dr_req(ISPC_DATA_W, 32'h0);
        end
        M_VF_DR: if (sc_done_reg) begin
          if (sc_res[ISPC_DATA_W-1:0] != exp_reg) begin
            verr_reg <= 1'b1;
            fail_reg <= 1'b1;
          end
          if (last_idx) begin
            st_reg <= M_EX_IR;
            req_reg <= 1'b1;
            rq_reg <= ir_req(IR_EXIT);
          end else begin
            idx_reg <= idx_reg + 16'h1;
            st_reg <= M_VF_GET;
          end
        end
        M_EX_IR: if (sc_done_reg) begin
          tmr_reg <= 32'(EXIT_CYC - 1);
          st_reg <= M_EX_W;
        end
        M_EX_W: if (tmr_zero) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          st_reg <= M_IDLE;
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end

  assign word_ready = rdy_reg;
  assign jtag = '{tck_reg, tms_reg, tdi_reg};
  assign stat = '{busy_reg, done_reg, id_ok_reg, fail_reg, verr_reg};

  // ------------------------------------------------------------------
  // Stage duration, order and result checks
  // ------------------------------------------------------------------
  ispc_state_t st_d_reg;
  logic [31:0] wcnt_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_d_reg <= M_IDLE;
      wcnt_reg <= 32'h0;
    end else begin
      st_d_reg <= st_reg;
      wcnt_reg <= (st_reg != st_d_reg) ? 32'h0 : wcnt_reg + 32'h1;
    end
  end

  enter_wait_a: assert property (st_reg == M_ID_IR &&
      st_d_reg == M_ENT_W |-> wcnt_reg == 32'(ENTER_CYC - 1))
    else $error("Enter stage wait has wrong length");
  exit_wait_a: assert property (st_reg == M_IDLE &&
      st_d_reg == M_EX_W |-> wcnt_reg == 32'(EXIT_CYC - 1))
    else $error("Exit stage wait has wrong length");
  erase_wait_a: assert property (st_reg == M_PG_IR &&
      st_d_reg == M_ER_W |-> wcnt_reg == 32'(ERASE_CYC - 1))
    else $error("Erase pulse wait has wrong length");
  stage_order_a: assert property (st_reg == M_PG_IR &&
      st_d_reg != M_PG_IR |-> st_d_reg == M_ER_W)
    else $error("Program stage not preceded by erase");
  verify_only_a: assert property (vonly_reg && busy_reg |->
      !(st_reg inside {M_ER_IR, M_ER_W, M_PG_IR, M_PG_GET, M_PG_DR, M_PG_W}))
    else $error("Verify-only run entered erase or program");
  id_first_a: assert property (st_reg inside {M_ER_IR, M_VF_IR} &&
      st_d_reg != st_reg |-> id_ok_reg)
    else $error("Program or verify without identity check");
  id_check_a: assert property (st_reg == M_ID_DR &&
      sc_done_reg && !cmd.abort |=>
      id_ok_reg == ($past(sc_res) == EXPECT_ID))
    else $error("Identity compare result wrong");
  vfy_cmp_a: assert property (st_reg == M_VF_DR &&
      sc_done_reg && !cmd.abort && sc_res[ISPC_DATA_W-1:0] != exp_reg
      |=> verr_reg && fail_reg)
    else $error("Verify mismatch not flagged");
  pgm_shift_a: assert property (st_reg == M_PG_GET &&
      pop && !cmd.abort |=> req_reg && st_reg == M_PG_DR &&
      rq_reg.len == 6'(ISPC_ADDR_W + ISPC_DATA_W))
    else $error("Program word not shifted");
  read_out_a: assert property (st_reg == M_VF_W &&
      tmr_zero && !cmd.abort |=> req_reg && st_reg == M_VF_DR &&
      rq_reg.len == 6'(ISPC_DATA_W))
    else $error("Read-out scan not issued after read pulse");
endmodule : ispc_programmer

// *** sim/ispc_dev_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Device end of the test port
// ------------------------------------------------
module ispc_dev_model #(
  parameter logic [9:0] IR_EN = 10'h011,
  parameter logic [9:0] IR_ID = 10'h012,
  parameter logic [9:0] IR_ER = 10'h013,
  parameter logic [9:0] IR_PG = 10'h014,
  parameter logic [9:0] IR_VF = 10'h015,
  parameter logic [9:0] IR_EX = 10'h016,
  parameter real EN_NS = 1000.0,
  parameter real EX_NS = 1000.0,
  parameter real ER_NS = 1000.0,
  parameter real PG_NS = 100.0,
  parameter real RD_NS = 50.0
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [31:0] id_val,
  input wire logic flip,
  output logic tdo,
  output logic pins_float
);
  // Next TAP state per state, tms=1 in the high nibble
  localparam logic [127:0] TBL = 128'h21FBEDFDCBCB0A21_8476865454932101;
  logic [3:0] st = 4'h0;
  logic [9:0] ir_sh = 10'h000;
  logic [9:0] ir = 10'h000;
  logic [31:0] dr_sh = 32'h0;
  logic [7:0] ra = 8'h00;
  logic [15:0] mem [256];
  int cnt = 0;
  int viol = 0;
  real t_mark = 0.0;
  real wait_ns = 0.0;
  logic [9:0] ir_log [$];
  // Four user pins: one on each global source, one tied off, one tied on;
  // programming floats them all, even the tied-on pin
  logic global_out_en_in_a_n = 1'b0;
  logic global_out_en_in_b_n = 1'b1;
  localparam logic [3:0] MC_OUT = 4'h5;
  localparam logic [3:0] PIN_IN = 4'hA;
  logic [5:0] glob_oe;
  logic [3:0] pin_oe;
  logic [3:0] mc_fb;
  logic [3:0] pin_fb;
  assign glob_oe = {MC_OUT[3], PIN_IN[3], global_out_en_in_b_n,
    global_out_en_in_a_n, !global_out_en_in_b_n, !global_out_en_in_a_n};
  assign pin_oe = {!pins_float, 1'b0,
    glob_oe[1] && !pins_float, glob_oe[0] && !pins_float};
  assign mc_fb = MC_OUT;
  assign pin_fb = (pin_oe & MC_OUT) | (~pin_oe & PIN_IN);
  initial begin
    tdo = 1'b0;
    pins_float = 1'b0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  task automatic mark(input real ns);
    t_mark = $realtime;
    wait_ns = ns;
  endtask : mark
  // Behavioural: no setup checks, only pulse spacing is policed
  always @(posedge tck) begin
    if (st == 4'd3 || st == 4'd10) begin
      if ($realtime - t_mark < wait_ns) viol++;
      wait_ns = 0.0;
      if (ir == IR_ID) dr_sh = id_val;
      else dr_sh = {16'h0000, mem[ra] ^ {15'h0, flip}};
      cnt = 0;
    end
    if (st == 4'd4) begin
      dr_sh = {tdi, dr_sh[31:1]};
      cnt++;
    end
    if (st == 4'd11) ir_sh = {tdi, ir_sh[9:1]};
    if (st == 4'd8 && ir == IR_PG && cnt == 24) begin
      mem[dr_sh[15:8]] = dr_sh[31:16];
      mark(PG_NS);
    end
    if (st == 4'd8 && ir == IR_VF && cnt == 8) begin
      ra = dr_sh[31:24];
      mark(RD_NS);
    end
    if (st == 4'd15) begin
      ir = ir_sh;
      ir_log.push_back(ir);
      if (ir == IR_EN) pins_float = 1'b1;
      if (ir == IR_EN) mark(EN_NS);
      if (ir == IR_EX) pins_float = 1'b0;
      if (ir == IR_EX) mark(EX_NS);
      if (ir == IR_ER) foreach (mem[i]) mem[i] = 16'hFFFF;
      if (ir == IR_ER) mark(ER_NS);
    end
    if (st == 4'd0) begin
      pins_float = 1'b0;
      ir = IR_ID;
    end
    st = tms ? TBL[{st, 3'b100} +: 4] : TBL[{st, 3'b000} +: 4];
  end
  // Outside shifting the line toggles rather than hold a stale bit
  always @(negedge tck) tdo <= (st == 4'd4) ? dr_sh[0] : ~tdo;
endmodule : ispc_dev_model

// *** sim/tb_ispc_programmer.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Bench
// ------------------------------------------------
module tb_ispc_programmer;
  import ispc_pkg::*;
  localparam int NA = 3;
  // Arbitrary value
  localparam logic [31:0] ID = 32'h2468_ACE1;
  localparam ispc_ir_t I_EN = 10'h0A1;
  localparam ispc_ir_t I_ID = 10'h0A2;
  localparam ispc_ir_t I_ER = 10'h0A3;
  localparam ispc_ir_t I_PG = 10'h0A4;
  localparam ispc_ir_t I_VF = 10'h0A5;
  localparam ispc_ir_t I_EX = 10'h0A6;
  typedef struct packed {
    logic [3:0] st;
    logic [59:0] irs;
    logic [2:0] n;
  } ispc_note_t;
  logic clk;
  logic nrst;
  ispc_cmd_t cmd;
  logic word_valid = 1'b0;
  ispc_word_t word;
  logic word_ready;
  ispc_jtag_t jtag;
  logic tdo;
  ispc_stat_t stat;
  logic [31:0] id_val;
  logic flip;
  logic pf;
  logic taken = 1'b0;
  logic done_d = 1'b0;
  ispc_note_t notes [$];
  ispc_note_t nt;
  ispc_word_t wq [$];
  ispc_word_t w [NA];
  int failures = 0;
  int cmp_count = 0;
  ispc_programmer #(.ENTER_CYC(40), .EXIT_CYC(40), .ERASE_CYC(60),
    .PROG_CYC(20), .READ_CYC(10), .NUM_ADDR(NA), .EXPECT_ID(ID),
    .IR_ENTER(I_EN), .IR_IDCODE(I_ID), .IR_ERASE(I_ER), .IR_PROG(I_PG),
    .IR_VERIFY(I_VF), .IR_EXIT(I_EX)) dut (.clk(clk), .nrst(nrst),
    .cmd(cmd), .word_valid(word_valid), .word(word),
    .word_ready(word_ready), .jtag(jtag), .tdo(tdo), .stat(stat));
  ispc_dev_model #(.IR_EN(I_EN), .IR_ID(I_ID), .IR_ER(I_ER), .IR_PG(I_PG),
    .IR_VF(I_VF), .IR_EX(I_EX), .EN_NS(200.0), .EX_NS(200.0),
    .ER_NS(300.0), .PG_NS(100.0), .RD_NS(50.0)) dev (.tck(jtag.tck),
    .tms(jtag.tms), .tdi(jtag.tdi), .id_val(id_val), .flip(flip),
    .tdo(tdo), .pins_float(pf));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(string nm, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic run(logic vo, logic [59:0] irs, logic [2:0] n,
    logic [3:0] st, int nw, logic ab);
    notes.push_back('{st, irs, n});
    dev.ir_log.delete();
    for (int k = 0; k < nw; k++) wq.push_back(w[k % NA]);
    @(negedge clk);
    cmd.start = 1'b1;
    cmd.verify_only = vo;
    @(negedge clk);
    cmd.start = 1'b0;
    check("busy", 1, stat.busy);
    if (ab) begin
      for (int k = 0; k < 20000 && dev.ir_log.size() < 3; k++) @(negedge clk);
      check("float", 1, pf);
      check("oe", 0, dev.pin_oe);
      check("ready", 0, word_ready);
      cmd.abort = 1'b1;
      @(negedge clk);
      cmd.abort = 1'b0;
    end
    for (int k = 0; k < 20000 && stat.done !== 1'b1; k++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : run
  // Word feeder: a raised word stands until taken, random gaps
  always @(negedge clk) begin
    if (taken) void'(wq.pop_front());
    if (taken || !word_valid) begin
      word_valid <= wq.size() != 0 && $urandom_range(3) != 0;
      if (wq.size() != 0) word <= wq[0];
    end
  end
  // Monitor: one note per finished run
  always @(posedge clk) begin
    taken <= word_valid && word_ready;
    done_d <= stat.done;
    if (stat.done === 1'b1 && done_d === 1'b0) begin
      nt = notes.pop_front();
      check("status", nt.st, stat[3:0]);
      check("scans", nt.n, dev.ir_log.size());
      for (int k = 0; k < nt.n; k++)
        check("instr", nt.irs[k*10 +: 10], dev.ir_log[k]);
      check("pins", 0, pf);
      check("oe", 4'h9, dev.pin_oe);
      check("feedback", 8'h53, {dev.mc_fb, dev.pin_fb});
      check("pulses", 0, dev.viol);
      if (nt.st != 4'hE)
        check("exit", 1, $realtime - dev.t_mark >= dev.wait_ns);
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(53069));
    nrst = 1'b0;
    cmd = '0;
    word = '0;
    id_val = ID;
    flip = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int k = 0; k < NA; k++) begin
      w[k].addr = 8'(k * 16) + 8'($urandom_range(15));
      w[k].data = 16'($urandom);
    end
    run(0, {I_EX, I_VF, I_PG, I_ER, I_ID, I_EN}, 6, 4'hC, 2 * NA,
      0);
    for (int k = 0; k < NA; k++)
      check("cell", w[k].data, dev.mem[w[k].addr]);
    check("erased", 16'hFFFF, dev.mem[8'hFF]);
    run(1, {20'h0, I_EX, I_VF, I_ID, I_EN}, 4, 4'hC, NA, 0);
    flip = 1'b1;
    run(1, {20'h0, I_EX, I_VF, I_ID, I_EN}, 4, 4'hF, NA, 0);
    flip = 1'b0;
    id_val = ~ID;
    run(0, {30'h0, I_EX, I_ID, I_EN}, 3, 4'hA, 0, 0);
    id_val = ID;
    run(0, {30'h0, I_ER, I_ID, I_EN}, 3, 4'hE, 2 * NA, 1);
    // A run that never finished leaves its note behind
    check("results", 0, notes.size());
    conclude();
  end
endmodule : tb_ispc_programmer
